// ===== hdl/pci_target_with_wake.sv
// Functional notes
// - all logic on the bus clock
// - address parity one clock after address
// - data parity one clock after ready
// - data moves only with both readies
// - target stop ends unsupported bursts
// - config cycles need idsel asserted
// - devsel driven on own decode
// - interrupt request drives inta low
// - ring in cold state with aux power present restores defaults
// - aux power present means cold supported
// - held in reset while rst_n low
module pci_target_with_wake
  import pcitw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic [31:0] adIn,
  output logic      [31:0] adOut,
  output logic             adOe,
  input  wire logic [3:0]  cbeIn,
  input  wire logic        parIn,
  output logic             parOut,
  output logic             parOe,
  input  wire logic        frameIn_n,
  input  wire logic        irdyIn_n,
  output logic             trdyOut_n,
  output logic             stopOut_n,
  output logic             devselOut_n,
  output logic             ctlOe,
  input  wire logic        devselIn_n,
  input  wire logic        idsel,
  output logic             inta_n,
  input  wire logic        intReq,
  input  wire logic        ringIn,
  input  wire logic        auxPowerPresent,
  input  wire logic        coldState,
  output logic             pme_n,
  output logic             parityErr,
  output logic             busSeen,
  output logic             coldSupport
);
  // ==========================================================
  // state
  pcitw_state_type stateQ, stateD;
  logic        isWriteQ, isCfgQ, dataPhaseQ;
  logic [1:0]  wordQ;
  logic [31:0] cfgQ [CFG_WORDS];
  logic [31:0] barQ;
  logic        pmeEnQ, parChkQ, parChkWrQ;
  logic [35:0] prevQ;
  logic        wakeQ;

  // ==========================================================
  // decode of the address phase
  wire logic addrPhase = (stateQ == PCITW_IDLE) && !frameIn_n;
  wire logic cfgCmd    = (cbeIn == CMD_CFG_READ) || (cbeIn == CMD_CFG_WRITE);
  wire logic memCmd    = (cbeIn == CMD_MEM_READ) || (cbeIn == CMD_MEM_WRITE);
  wire logic cfgHit    = cfgCmd && idsel && (adIn[1:0] == 2'b00);
  wire logic memHit    = memCmd && ((adIn & BAR_MASK) == barQ)
                         && (barQ != MEM_RESET);
  wire logic hit       = addrPhase && (cfgHit || memHit);
  wire logic xfer      = dataPhaseQ && !irdyIn_n && !trdyOut_n;
  wire logic lastXfer  = xfer && frameIn_n;
  wire logic endPhase  = lastXfer || (!stopOut_n && frameIn_n);
  wire logic ringWake  = coldState && auxPowerPresent && ringIn;
  wire logic calcPar;

  // parity over the previous cycle's bus values
  pcitw_parity pcitw_parity_i
  (
    .ad  (prevQ[35:4]),
    .cbe (prevQ[3:0]),
    .par (calcPar)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    stateD = stateQ;
    case (stateQ)
      PCITW_IDLE: if (hit) stateD = PCITW_DATA;
                  else if (addrPhase) stateD = PCITW_BUSY;
      PCITW_DATA: if (lastXfer || (!stopOut_n && frameIn_n))
                    stateD = PCITW_TURN;
      PCITW_TURN: stateD = PCITW_IDLE;
      PCITW_BUSY: if (frameIn_n && irdyIn_n) stateD = PCITW_IDLE;
      default:    stateD = PCITW_IDLE;
    endcase
  end

  // ==========================================================
  // transaction flow, single clock sync reset
  always_ff @(posedge clock)
  begin
    if (!rst_n || ringWake)
    begin
      stateQ <= PCITW_IDLE;
      isWriteQ <= 1'b0;
      isCfgQ <= 1'b0;
      dataPhaseQ <= 1'b0;
      wordQ <= 2'h0;
      trdyOut_n <= 1'b1;
      stopOut_n <= 1'b1;
      devselOut_n <= 1'b1;
      ctlOe <= 1'b0;
    end
    else if (clkEn)
    begin
      stateQ <= stateD;
      if (hit)
      begin
        isWriteQ <= cbeIn[0];
        isCfgQ <= cfgHit;
        wordQ <= adIn[3:2];
        dataPhaseQ <= 1'b1;
        devselOut_n <= 1'b0;
        trdyOut_n <= 1'b0;
        stopOut_n <= 1'b1;
        ctlOe <= 1'b1;
      end
      else if (dataPhaseQ)
      begin
        if (lastXfer || (!stopOut_n && frameIn_n))
        begin
          dataPhaseQ <= 1'b0;
          devselOut_n <= 1'b1;
          trdyOut_n <= 1'b1;
          stopOut_n <= 1'b1;
        end
        else if (xfer)
        begin
          // single data phase only: disconnect further bursts
          trdyOut_n <= 1'b1;
          stopOut_n <= 1'b0;
        end
      end
      else
        ctlOe <= 1'b0;
    end
  end

  // ==========================================================
  // config space and memory window registers
  always_ff @(posedge clock)
  begin
    if (!rst_n || ringWake)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
        cfgQ[i] <= MEM_RESET;
      barQ <= MEM_RESET;
      pmeEnQ <= 1'b0;
    end
    else if (clkEn && xfer && isWriteQ)
    begin
      if (isCfgQ && wordQ == 2'h1)
        pmeEnQ <= adIn[8];
      if (isCfgQ && wordQ == 2'h2)
        barQ <= adIn & BAR_MASK;
      else
        cfgQ[wordQ] <= adIn;
    end
  end

  // read data: word 0 holds the id, word 2 the window base; the index
  // comes off the bus in the address phase so data stands with trdy
  wire logic [1:0]  rdIndex = hit ? adIn[3:2] : wordQ;
  wire logic [31:0] rdData  = (rdIndex == 2'h0) ? CFG_ID_RESET :
                              (rdIndex == 2'h2) ? barQ : cfgQ[rdIndex];

  // ==========================================================
  // read data drive and parity one clock after the phase
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      adOut <= 32'h0;
      adOe <= 1'b0;
      parOut <= 1'b0;
      parOe <= 1'b0;
      prevQ <= 36'h0;
      parChkQ <= 1'b0;
      parChkWrQ <= 1'b0;
      parityErr <= 1'b0;
    end
    else if (clkEn)
    begin
      prevQ <= {adIn, cbeIn};
      adOut <= rdData;
      adOe <= hit ? !cbeIn[0] : (dataPhaseQ && !isWriteQ && !endPhase);
      // read parity follows trdy by one clock
      parOe <= adOe;
      parOut <= ^{adOut, cbeIn};
      // address and write data parity checked next clock
      parChkQ <= addrPhase;
      parChkWrQ <= dataPhaseQ && isWriteQ && !irdyIn_n;
      parityErr <= (parChkQ || parChkWrQ) && (calcPar != parIn);
    end
  end

  // ==========================================================
  // interrupt, wake and status pins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      inta_n <= 1'b1;
      pme_n <= 1'b1;
      wakeQ <= 1'b0;
      busSeen <= 1'b0;
      coldSupport <= 1'b0;
    end
    else if (clkEn)
    begin
      inta_n <= !intReq;
      coldSupport <= auxPowerPresent;
      busSeen <= !devselIn_n;
      // wake latch: set wins, cleared when cold state left
      wakeQ <= (ringWake && pmeEnQ) || (wakeQ && coldState);
      pme_n <= !((ringWake && pmeEnQ) || (wakeQ && coldState));
    end
  end

  // ==========================================================
  // checks
  chk_xfer_needs_both: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && dataPhaseQ && (irdyIn_n || trdyOut_n) && !ringWake
    |=> $stable(barQ) && $stable(pmeEnQ))
    else $error("register written without both readies");
  chk_devsel_on_hit: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && hit && !ringWake |=> !devselOut_n)
    else $error("devsel not driven after hit");
  chk_cfg_idsel: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && addrPhase && cfgCmd && !idsel |=> devselOut_n)
    else $error("config claimed without idsel");
  chk_stop_after_xfer: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && xfer && !frameIn_n && !ringWake |=> !stopOut_n)
    else $error("no stop after burst data");
  chk_inta_follow: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && intReq |=> !inta_n)
    else $error("interrupt not asserted");
  chk_cold_support: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn |=> coldSupport == $past(auxPowerPresent))
    else $error("cold support mismatch");
  chk_ring_resets: assert property (@(posedge clock) disable iff (!rst_n)
    ringWake |=> stateQ == PCITW_IDLE && devselOut_n)
    else $error("ring did not restore defaults");
  chk_pme_wake: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && ringWake && pmeEnQ |=> !pme_n)
    else $error("pme not asserted on wake");
  chk_read_par: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && adOe ##1 clkEn |-> parOe)
    else $error("read parity not driven");
  chk_reset_idle: assert property (@(posedge clock)
    !rst_n |=> stateQ == PCITW_IDLE && trdyOut_n)
    else $error("not idle after reset");
  cov_cfg_write: cover property (@(posedge clock)
    xfer && isCfgQ && isWriteQ);
  cov_mem_read: cover property (@(posedge clock) xfer && !isCfgQ && !isWriteQ);
  cov_wake: cover property (@(posedge clock) !pme_n);
endmodule // pci_target_with_wake

// ===== hdl/pcitw_pkg.sv
package pcitw_pkg;
  // ==========================================================
  // bus command codes
  localparam logic [3:0] CMD_CFG_READ  = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  // ==========================================================
  // timing
  localparam int CLOCK_MHZ       = 200;
  localparam int PCI_MHZ         = 33;
  // number of config dwords implemented
  localparam int CFG_WORDS       = 4;
  localparam logic [31:0] CFG_ID_RESET = 32'h0000_1234; // arbitrary id
  localparam logic [31:0] MEM_RESET    = 32'h0000_0000;
  localparam logic [31:0] BAR_MASK     = 32'hffff_f000;
  // ==========================================================
  // target states
  typedef enum logic [2:0] {
    PCITW_IDLE = 3'b000,
    PCITW_DATA = 3'b001,
    PCITW_TURN = 3'b010,
    PCITW_BUSY = 3'b011
  } pcitw_state_type;
endpackage

// ===== hdl/pcitw_parity.sv
// ==========================================================
// even parity over address/data and command/byte enables
module pcitw_parity
  import pcitw_pkg::*;
(
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe,
  output wire logic        par
);
  // one xor tree
  assign par = ^{ad, cbe};
endmodule // pcitw_parity

// ===== verif/pcitw_master.sv
// ==========================================
// bus master model, one data phase or two
module pcitw_master
  import pcitw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [31:0] adOut,
  input  wire logic        adOe,
  input  wire logic        parOut,
  input  wire logic        parOe,
  input  wire logic        trdyOut_n,
  input  wire logic        stopOut_n,
  input  wire logic        devselOut_n,
  output wire logic [31:0] adIn,
  output logic      [3:0]  cbeIn,
  output wire logic        parIn,
  output logic             frameIn_n,
  output logic             irdyIn_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] adDrv = 32'h0;
  logic        parDrv = 1'b0;
  // wired bus: the target wins while it drives
  assign adIn  = adOe ? adOut : adDrv;
  assign parIn = parOe ? parOut : parDrv;
  // idle bus levels
  initial
  begin
    frameIn_n = 1'b1;
    irdyIn_n  = 1'b1;
    cbeIn     = 4'hf;
  end
  // address phase, data phase, optional second phase
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, w,
                      input logic bad, burst,
                      output logic [31:0] rd, output logic hit, stp, pok);
    hit = 1'b0;
    pok = 1'b1;
    stp = 1'b0;
    rd  = 32'h0;
    @(negedge clock);
    frameIn_n = 1'b0;
    adDrv     = a;
    cbeIn     = cmd;
    @(negedge clock);
    parDrv    = ^{a, cmd} ^ bad;
    frameIn_n = !burst;
    irdyIn_n  = 1'b0;
    cbeIn     = 4'h0;
    adDrv     = cmd[0] ? w : ~a;
    repeat (4)
    begin
      @(posedge clock);
      hit = hit | (devselOut_n === 1'b0);
      if (trdyOut_n === 1'b0)
      begin
        rd = adIn;
        break;
      end
    end
    @(negedge clock);
    parDrv = ^{adDrv, 4'h0};
    if (burst && hit)
    begin
      frameIn_n = 1'b1;
      repeat (4)
      begin
        @(posedge clock);
        stp = stp | (stopOut_n === 1'b0);
      end
      @(negedge clock);
    end
    frameIn_n = 1'b1;
    irdyIn_n  = 1'b1;
    cbeIn     = 4'hf;
    adDrv     = ~adDrv; // released bus shows no stale value
    // read parity stands the clock after a single data phase
    @(posedge clock);
    if (hit && !cmd[0] && !burst)
      pok = (parIn === ^{rd, 4'h0});
    @(negedge clock);
  endtask
endmodule // pcitw_master

// ===== verif/pci_target_with_wake_test.sv
// ==========================================
// self-checking bench for the target
module pci_target_with_wake_test
  import pcitw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, rst_n = 1'b0, idsel = 1'b0, intReq = 1'b1;
  logic        ringIn = 1'b0, auxPowerPresent = 1'b0, coldState = 1'b0;
  logic        extDevsel_n = 1'b1, devselIn_n, hit, stp, pok;
  logic [31:0] adIn, adOut, rd, v, w;
  logic [3:0]  cbeIn;
  logic        parIn, parOut, adOe, parOe, frameIn_n, irdyIn_n, trdyOut_n;
  logic        stopOut_n, devselOut_n, ctlOe, inta_n, pme_n, parityErr;
  logic        busSeen, coldSupport;
  int          miscompares = 0, total_checks = 0, cycles = 0, perrs = 0;
  int          seed = 32'h3e643ad0;
  assign devselIn_n = extDevsel_n & (ctlOe ? devselOut_n : 1'b1);
  pci_target_with_wake pci_target_with_wake_i (.clock(clock), .rst_n(rst_n),
    .clkEn(1'b1), .adIn(adIn), .adOut(adOut), .adOe(adOe), .cbeIn(cbeIn),
    .parIn(parIn), .parOut(parOut), .parOe(parOe), .frameIn_n(frameIn_n),
    .irdyIn_n(irdyIn_n), .trdyOut_n(trdyOut_n), .stopOut_n(stopOut_n),
    .devselOut_n(devselOut_n), .ctlOe(ctlOe), .devselIn_n(devselIn_n),
    .idsel(idsel), .inta_n(inta_n), .intReq(intReq), .ringIn(ringIn),
    .auxPowerPresent(auxPowerPresent), .coldState(coldState),
    .pme_n(pme_n), .parityErr(parityErr), .busSeen(busSeen),
    .coldSupport(coldSupport));
  pcitw_master pcitw_master_i (.clock(clock), .adOut(adOut), .adOe(adOe),
    .parOut(parOut), .parOe(parOe), .trdyOut_n(trdyOut_n),
    .stopOut_n(stopOut_n), .devselOut_n(devselOut_n), .adIn(adIn),
    .cbeIn(cbeIn), .parIn(parIn), .frameIn_n(frameIn_n),
    .irdyIn_n(irdyIn_n));
  // 200 MHz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // parity error pulses and hang limit
  always @(posedge clock)
  begin
    cycles++;
    if (parityErr === 1'b1) perrs++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================
  // compare, stimulus and closing tasks
  task automatic cmp1(input logic g, e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task automatic cmp32(input logic [31:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t word got %h exp %h", $time, g, e);
    end
  endtask
  // window read: word 0 id, word 2 base, other words hold written data
  function automatic logic [31:0] memExp(input logic [31:0] b, d);
    case (d[3:2])
      2'h0:    memExp = CFG_ID_RESET;
      2'h2:    memExp = b;
      default: memExp = d;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic op(input logic [3:0] c, input logic [31:0] a, d,
                    input logic s, bad, b);
    idsel = s;
    pcitw_master_i.xfer(c, a, d, bad, b, rd, hit, stp, pok);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    cyc(20);
    cmp1(inta_n, 1'b1);
    cmp1(devselOut_n, 1'b1);
    rst_n = 1'b1;
    cyc(3);
    cmp1(inta_n, 1'b0);
    intReq = 1'b0;
    cyc(3);
    cmp1(inta_n, 1'b1);
    op(CMD_CFG_READ, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0);
    cmp32(rd, CFG_ID_RESET);
    cmp1(pok, 1'b1);
    repeat (4)
    begin
      v = ($random(seed) & BAR_MASK) | 32'h0010_0000;
      w = $random(seed);
      op(CMD_CFG_WRITE, 32'h8, v, 1'b1, 1'b0, 1'b0);
      op(CMD_CFG_READ, 32'h8, 32'h0, 1'b1, 1'b0, 1'b0);
      cmp32(rd, v);
      cmp1(pok, 1'b1);
      op(CMD_CFG_READ, 32'h8, 32'h0, 1'b0, 1'b0, 1'b0);
      cmp1(hit, 1'b0);
      op(CMD_MEM_WRITE, v | (w & 32'hffc), w, 1'b0, 1'b0, 1'b0);
      cmp1(hit, 1'b1);
      op(CMD_MEM_READ, v | (w & 32'hffc), 32'h0, 1'b0, 1'b0, 1'b0);
      cmp32(rd, memExp(v, w));
      cmp1(pok, 1'b1);
      op(CMD_MEM_READ, v ^ 32'h8000_0000, w, 1'b0, 1'b0, 1'b0);
      cmp1(hit, 1'b0);
      auxPowerPresent = w[5];
      cyc(2);
      cmp1(coldSupport, w[5]);
    end
    cmp1(perrs == 0, 1'b1);
    op(CMD_CFG_READ, 32'h0, 32'h0, 1'b1, 1'b1, 1'b0);
    cyc(3);
    cmp1(perrs > 0, 1'b1);
    op(CMD_CFG_READ, 32'h0, 32'h0, 1'b1, 1'b0, 1'b1);
    cmp1(stp, 1'b1);
    extDevsel_n = 1'b0;
    cyc(1);
    extDevsel_n = 1'b1;
    cmp1(busSeen, 1'b1);
    auxPowerPresent = 1'b1;
    op(CMD_CFG_WRITE, 32'h4, 32'h100, 1'b1, 1'b0, 1'b0);
    coldState = 1'b1;
    ringIn = 1'b1;
    cyc(1);
    ringIn = 1'b0;
    cyc(2);
    cmp1(pme_n, 1'b0);
    coldState = 1'b0;
    cyc(2);
    cmp1(pme_n, 1'b1);
    op(CMD_CFG_READ, 32'h8, 32'h0, 1'b1, 1'b0, 1'b0);
    cmp32(rd, 32'h0);
    stop_test();
  end
endmodule // pci_target_with_wake_test
